//--- mbhp_pkg.sv
package mbhp_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int IDX_W       = 3;
  localparam int DATA_W      = 8;
  localparam int LOW_W       = 3;
  localparam int HIGH_W      = 5;
  localparam int PIN_W       = 14;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // positions inside the synchronised pin word
  // ----------------------------------------------------------------
  localparam int POS_DATA = 0;
  localparam int POS_ADDR = 8;
  localparam int POS_RD   = 11;
  localparam int POS_WR   = 12;
  localparam int POS_CS   = 13;

  // address pin roles in shared-bus operation
  localparam int POS_STRAP = 0;
  localparam int POS_ALE   = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  // pins are pulled up, so the idle bus reads as all ones
  localparam logic [PIN_W-1:0]  PIN_IDLE   = 14'h3FFF;
  localparam logic [IDX_W-1:0]  IDX_RESET  = 3'h0;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } mbhp_state_t;

  typedef enum logic [1:0] {
    BUS_80XX = 2'b01,
    BUS_68XX = 2'b10
  } mbhp_bus_t;

endpackage : mbhp_pkg

//--- mbhp_pin_if.sv
`timescale 1ns/1ns
interface mbhp_pin_if;
  logic [mbhp_pkg::IDX_W-1:0]  addr;
  logic [mbhp_pkg::DATA_W-1:0] data;
  logic                        readStrobeN;
  logic                        storePulseN;
  logic                        chipSelectN;

  modport sync (output addr, output data, output readStrobeN, output storePulseN,
                output chipSelectN);
  modport core (input addr, input data, input readStrobeN, input storePulseN,
                input chipSelectN);
endinterface : mbhp_pin_if

//--- mbhp_sync.sv
`timescale 1ns/1ns
module mbhp_sync #(
  parameter int STAGES = mbhp_pkg::SYNC_STAGES
) (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       resetn,
  // raw host pins
  input  wire logic [mbhp_pkg::PIN_W-1:0] pinRaw,
  // synchronised pins
  mbhp_pin_if.sync                        pins
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (STAGES < 2) begin : g_bad_stages
    $error("mbhp_sync needs at least two stages");
  end

  // ----------------------------------------------------------------
  // flip-flop chain
  // ----------------------------------------------------------------
  logic [mbhp_pkg::PIN_W-1:0] stage      [STAGES];
  logic [mbhp_pkg::PIN_W-1:0] next_stage [STAGES];

  always_comb begin
    next_stage[0] = pinRaw;
    for (int i = 1; i < STAGES; i++) begin
      next_stage[i] = stage[i-1];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < STAGES; i++) begin
        stage[i] <= mbhp_pkg::PIN_IDLE;
      end
    end else begin
      stage <= next_stage;
    end
  end

  assign pins.data        = stage[STAGES-1][mbhp_pkg::POS_DATA +: mbhp_pkg::DATA_W];
  assign pins.addr        = stage[STAGES-1][mbhp_pkg::POS_ADDR +: mbhp_pkg::IDX_W];
  assign pins.readStrobeN = stage[STAGES-1][mbhp_pkg::POS_RD];
  assign pins.storePulseN = stage[STAGES-1][mbhp_pkg::POS_WR];
  assign pins.chipSelectN = stage[STAGES-1][mbhp_pkg::POS_CS];

endmodule : mbhp_sync

//--- mbhp_host_port.sv
`timescale 1ns/1ns
module mbhp_host_port (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        resetn,
  // host address pins: bit 0 doubles as strap, bit 2 as address latch
  input  wire logic [mbhp_pkg::IDX_W-1:0]  registerIndex,
  // host data pins
  input  wire logic [mbhp_pkg::LOW_W-1:0]  muxedAddrDataLowIn,
  input  wire logic [mbhp_pkg::HIGH_W-1:0] dataHighBitsIn,
  output logic      [mbhp_pkg::LOW_W-1:0]  muxedAddrDataLowOut,
  output logic      [mbhp_pkg::HIGH_W-1:0] dataHighBitsOut,
  output logic                             dataOeN,
  // host strobes: read pin doubles as data strobe, store pin as direction
  input  wire logic                        readStrobeN,
  input  wire logic                        storePulseN,
  input  wire logic                        chipSelectN,
  // host interrupt
  output logic                             interruptRequestN,
  // core side
  output logic      [mbhp_pkg::IDX_W-1:0]  coreIndex,
  output logic      [mbhp_pkg::DATA_W-1:0] coreWriteData,
  output logic                             coreWritePulse,
  output logic                             coreReadPulse,
  output logic                             coreBusIs68,
  input  wire logic [mbhp_pkg::DATA_W-1:0] coreReadData,
  input  wire logic [mbhp_pkg::DATA_W-1:0] intStatus,
  input  wire logic [mbhp_pkg::DATA_W-1:0] intMask
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // shared-bus index rides on the low data lines, so widths must agree
  if (mbhp_pkg::LOW_W != mbhp_pkg::IDX_W) begin : g_bad_low_w
    $error("mbhp_host_port needs low data lines as wide as the index");
  end
  if (mbhp_pkg::LOW_W + mbhp_pkg::HIGH_W != mbhp_pkg::DATA_W) begin : g_bad_data_w
    $error("mbhp_host_port needs low and high lines to fill the data word");
  end

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  mbhp_pin_if pins ();

  mbhp_sync #(
    .STAGES (mbhp_pkg::SYNC_STAGES)
  ) u_sync (
    .mclk   (mclk),
    .resetn (resetn),
    .pinRaw ({chipSelectN, storePulseN, readStrobeN, registerIndex,
              dataHighBitsIn, muxedAddrDataLowIn}),
    .pins   (pins.sync)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mbhp_pkg::mbhp_state_t         state;
  mbhp_pkg::mbhp_state_t         next_state;
  mbhp_pkg::mbhp_bus_t           busType;
  mbhp_pkg::mbhp_bus_t           next_busType;
  logic [mbhp_pkg::IDX_W-1:0]    latchIdx;
  logic [mbhp_pkg::IDX_W-1:0]    next_latchIdx;
  logic [mbhp_pkg::IDX_W-1:0]    next_coreIndex;
  logic [mbhp_pkg::DATA_W-1:0]   next_coreWriteData;
  logic                          next_coreWritePulse;
  logic                          next_coreReadPulse;
  logic [mbhp_pkg::DATA_W-1:0]   dataOut;
  logic [mbhp_pkg::DATA_W-1:0]   next_dataOut;
  logic                          next_dataOeN;
  logic                          next_interruptRequestN;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic                       selected;
  logic                       muxed;
  logic                       aleHigh;
  logic                       bothLow;
  logic                       isBus68;
  logic                       readReq;
  logic                       writeCond;
  logic [mbhp_pkg::IDX_W-1:0] liveIdx;

  assign selected = !pins.chipSelectN;
  assign muxed    = !pins.addr[mbhp_pkg::POS_STRAP];
  assign aleHigh  = pins.addr[mbhp_pkg::POS_ALE];
  assign bothLow  = !pins.readStrobeN && !pins.storePulseN;
  // both strobes low only happens on a 68xx write
  assign isBus68  = (busType == mbhp_pkg::BUS_68XX) || bothLow;
  // read looks the same in both styles: low strobe, other pin high
  assign readReq  = selected && !pins.readStrobeN && pins.storePulseN;
  // write window depends on the strobe style
  assign writeCond = selected &&
                     (isBus68 ? bothLow : (pins.readStrobeN && !pins.storePulseN));
  // index from pins or from the latched low data lines
  assign liveIdx  = muxed ? latchIdx : pins.addr;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_state          = state;
    next_busType        = busType;
    next_latchIdx       = latchIdx;
    next_coreIndex      = coreIndex;
    next_coreWriteData  = coreWriteData;
    next_coreWritePulse = 1'b0;
    next_coreReadPulse  = 1'b0;
    next_dataOut        = dataOut;
    // sticky once a 68xx write has been seen
    if (selected && bothLow) begin
      next_busType = mbhp_pkg::BUS_68XX;
    end
    // transparent latch while the latch strobe is high
    if (muxed && aleHigh) begin
      next_latchIdx = pins.data[mbhp_pkg::IDX_W-1:0];
    end
    unique case (state)
      mbhp_pkg::ST_IDLE: begin
        if (readReq) begin
          next_state         = mbhp_pkg::ST_READ;
          next_coreIndex     = liveIdx;
          next_coreReadPulse = 1'b1;
        end else if (writeCond) begin
          next_state         = mbhp_pkg::ST_WRITE;
          next_coreIndex     = liveIdx;
          next_coreWriteData = pins.data;
        end
      end
      mbhp_pkg::ST_READ: begin
        next_dataOut = coreReadData;
        if (!readReq) begin
          next_state = mbhp_pkg::ST_IDLE;
        end
      end
      mbhp_pkg::ST_WRITE: begin
        if (writeCond) begin
          // all eight lines are data here
          next_coreWriteData = pins.data;
        end else begin
          next_state = mbhp_pkg::ST_IDLE;
          // chip select lost mid-write drops the write
          next_coreWritePulse = selected;
        end
      end
    endcase
  end

  // drive only during a selected read, once data are valid
  assign next_dataOeN = !((state == mbhp_pkg::ST_READ) && readReq);

  // masked status decode, shared by the output and its checks
  function automatic logic anyEnabled(input logic [mbhp_pkg::DATA_W-1:0] status,
                                      input logic [mbhp_pkg::DATA_W-1:0] mask);
    return |(status & mask);
  endfunction : anyEnabled

  // level of masked status, no latching here
  assign next_interruptRequestN = !anyEnabled(intStatus, intMask);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // reset input clears all port state
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state             <= mbhp_pkg::ST_IDLE;
      busType           <= mbhp_pkg::BUS_80XX;
      latchIdx          <= mbhp_pkg::IDX_RESET;
      coreIndex         <= mbhp_pkg::IDX_RESET;
      coreWriteData     <= mbhp_pkg::DATA_RESET;
      coreWritePulse    <= 1'b0;
      coreReadPulse     <= 1'b0;
      dataOut           <= mbhp_pkg::DATA_RESET;
      dataOeN           <= 1'b1;
      interruptRequestN <= 1'b1;
    end else begin
      state             <= next_state;
      busType           <= next_busType;
      latchIdx          <= next_latchIdx;
      coreIndex         <= next_coreIndex;
      coreWriteData     <= next_coreWriteData;
      coreWritePulse    <= next_coreWritePulse;
      coreReadPulse     <= next_coreReadPulse;
      dataOut           <= next_dataOut;
      dataOeN           <= next_dataOeN;
      interruptRequestN <= next_interruptRequestN;
    end
  end

  assign muxedAddrDataLowOut = dataOut[mbhp_pkg::LOW_W-1:0];
  assign dataHighBitsOut     = dataOut[mbhp_pkg::DATA_W-1:mbhp_pkg::LOW_W];
  assign coreBusIs68         = busType[1];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence s_read_start;
    (state == mbhp_pkg::ST_IDLE) && readReq ##1 readReq;
  endsequence

  sequence s_latch_close;
    (muxed && aleHigh) ##1 (muxed && !aleHigh);
  endsequence

  a_index_direct: assert property (
    (state == mbhp_pkg::ST_IDLE) && readReq && !muxed |=> coreIndex == $past(pins.addr))
    else $error("index not taken from address pins");

  a_index_muxed: assert property (
    s_latch_close |-> latchIdx == $past(pins.data[mbhp_pkg::IDX_W-1:0]))
    else $error("index not taken from latched data lines");

  a_index_latched: assert property (
    (state == mbhp_pkg::ST_IDLE) && writeCond && muxed |=> coreIndex == $past(latchIdx))
    else $error("shared-bus write not using latched index");

  a_high_data: assert property (
    (state == mbhp_pkg::ST_WRITE) && writeCond |=> coreWriteData[7:3] == $past(pins.data[7:3]))
    else $error("upper data lines not carried as data");

  a_write_68xx: assert property (
    (busType == mbhp_pkg::BUS_68XX) && (state == mbhp_pkg::ST_WRITE) && selected
      && pins.readStrobeN |=> coreWritePulse)
    else $error("68xx write not taken at strobe end");

  a_strobe_gate: assert property (
    (busType == mbhp_pkg::BUS_68XX) && (state == mbhp_pkg::ST_IDLE) && pins.readStrobeN
      |=> state == mbhp_pkg::ST_IDLE)
    else $error("68xx access started without data strobe");

  a_write_80xx: assert property (
    (busType == mbhp_pkg::BUS_80XX) && (state == mbhp_pkg::ST_WRITE) && selected
      && !bothLow && pins.storePulseN |=> coreWritePulse)
    else $error("80xx write not taken at store pulse end");

  a_write_single: assert property (
    coreWritePulse |=> !coreWritePulse)
    else $error("write pulse longer than one cycle");

  a_read_drive: assert property (
    s_read_start |=> !dataOeN && ({dataHighBitsOut, muxedAddrDataLowOut} == $past(coreReadData)))
    else $error("read data not driven");

  a_read_pulse: assert property (
    (state == mbhp_pkg::ST_IDLE) && readReq |=> coreReadPulse && (state == mbhp_pkg::ST_READ))
    else $error("read not started");

  a_write_select: assert property (
    coreWritePulse |-> $past(selected))
    else $error("write taken without chip select");

  a_deselect_quiet: assert property (
    !selected && (state == mbhp_pkg::ST_IDLE)
      |=> !coreReadPulse && (state == mbhp_pkg::ST_IDLE))
    else $error("access started without chip select");

  a_bus_detect: assert property (
    selected && bothLow |=> coreBusIs68 [*2])
    else $error("68xx style not detected");

  a_idle_no_drive: assert property (
    !readReq |=> dataOeN)
    else $error("data lines driven outside a read");

  a_reset_state: assert property (
    $rose(resetn) |-> dataOeN && interruptRequestN && !coreWritePulse)
    else $error("outputs not at reset values");

  a_irq_raise: assert property (
    $rose(anyEnabled(intStatus, intMask)) |=> !interruptRequestN)
    else $error("interrupt not raised");

  a_irq_masked: assert property (
    !anyEnabled(intStatus, intMask) |=> interruptRequestN)
    else $error("masked condition raised interrupt");

  a_irq_held: assert property (
    anyEnabled(intStatus, intMask) [*3] |-> !interruptRequestN && $past(!interruptRequestN))
    else $error("interrupt released while condition holds");

endmodule : mbhp_host_port

//--- mbhp_host_model.sv
`timescale 1ns/1ns
module mbhp_host_model (
  // clock
  input  wire logic       mclk,
  // host pins
  output logic      [2:0] addr,
  output logic      [7:0] dOut,
  output logic            dOe,
  output logic            rdN,
  output logic            wrN,
  output logic            csN,
  input  wire logic [7:0] busIn
);
  initial begin
    addr = 3'h1;
    dOut = 8'h00;
    dOe = 1'b0;
    rdN = 1'b1;
    wrN = 1'b1;
    csN = 1'b1;
  end

  // one host cycle; strobes held 8 clocks, gaps of 3+ for the synchroniser
  task automatic xfer(input logic is68, input logic isRd, input logic [2:0] a,
                      input logic [7:0] d, input logic selN, output logic [7:0] q);
    @(negedge mclk);
    addr = a;
    csN = selN;
    dOut = d;
    dOe = !isRd;
    if (is68) begin
      wrN = isRd;
      repeat (3) @(negedge mclk);
      rdN = 1'b0;
    end else if (isRd) begin
      rdN = 1'b0;
    end else begin
      wrN = 1'b0;
    end
    repeat (8) @(negedge mclk);
    q = busIn;
    rdN = 1'b1;
    if (!is68) wrN = 1'b1;
    repeat (3) @(negedge mclk);
    wrN = 1'b1;
    dOe = 1'b0;
    csN = 1'b1;
    repeat (4) @(negedge mclk);
  endtask : xfer

  // strap low, latch strobe on the top pin
  task automatic latch(input logic [2:0] a, input logic [4:0] junk);
    @(negedge mclk);
    addr = 3'h4;
    dOe = 1'b1;
    dOut = {junk, a};
    repeat (4) @(negedge mclk);
    addr = 3'h0;
    repeat (3) @(negedge mclk);
  endtask : latch
endmodule : mbhp_host_model

//--- tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic       mclk;
  logic       resetn;
  logic [2:0] addr;
  logic [7:0] dOut;
  logic       dOe;
  logic       rdN;
  logic       wrN;
  logic       csN;
  logic [7:0] bus;
  logic [2:0] loOut;
  logic [4:0] hiOut;
  logic       oeN;
  logic       irqN;
  logic [2:0] cIdx;
  logic [7:0] cWd;
  logic       cWp;
  logic       cRp;
  logic       is68;
  logic [7:0] cRd;
  logic [7:0] iSt;
  logic [7:0] iMk;
  logic [2:0] wIdx;
  logic [2:0] rIdx;
  logic [7:0] wDat;
  int         n_fail;
  int         check_count;
  int         store_pulse_n;
  int         read_strobe_n;

  function automatic logic [7:0] rdVal(input logic [2:0] i);
    return {i ^ 3'h5, 2'h2, i};
  endfunction : rdVal

  // released lines float to the pull-up level
  assign bus = dOe ? dOut : ((oeN === 1'b0) ? {hiOut, loOut} : 8'hFF);
  assign cRd = rdVal(cIdx);

  mbhp_host_model i_host (.mclk(mclk), .addr(addr), .dOut(dOut), .dOe(dOe), .rdN(rdN),
                          .wrN(wrN), .csN(csN), .busIn(bus));

  mbhp_host_port i_dut (.mclk(mclk), .resetn(resetn), .registerIndex(addr),
    .muxedAddrDataLowIn(bus[2:0]), .dataHighBitsIn(bus[7:3]),
    .muxedAddrDataLowOut(loOut), .dataHighBitsOut(hiOut), .dataOeN(oeN),
    .readStrobeN(rdN), .storePulseN(wrN), .chipSelectN(csN), .interruptRequestN(irqN),
    .coreIndex(cIdx), .coreWriteData(cWd), .coreWritePulse(cWp), .coreReadPulse(cRp),
    .coreBusIs68(is68), .coreReadData(cRd), .intStatus(iSt), .intMask(iMk));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // pulses are looked at mid-cycle, well clear of the edge that launches them
  always @(negedge mclk) begin
    if (cWp === 1'b1) begin
      store_pulse_n++;
      wIdx = cIdx;
      wDat = cWd;
    end
    if (cRp === 1'b1) begin
      read_strobe_n++;
      rIdx = cIdx;
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    close_out();
  end

  initial begin
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] q;
    int         p;
    int         seed;
    resetn = 1'b0;
    iSt = 8'h00;
    iMk = 8'h00;
    seed = $urandom(75221);
    repeat (8) @(negedge mclk);
    resetn = 1'b1;
    // ----------------------------------------------------------------
    // interrupt masking
    // ----------------------------------------------------------------
    for (int k = 0; k < 24; k++) begin
      iSt = (k < 2) ? 8'h80 : 8'($urandom);
      iMk = (k == 0) ? 8'h7F : (k == 1) ? 8'h80 : 8'($urandom);
      @(negedge mclk);
      chk(irqN, ~|(iSt & iMk));
    end
    // ----------------------------------------------------------------
    // split-strobe writes, reads and deselected cycles
    // ----------------------------------------------------------------
    for (int k = 0; k < 6; k++) begin
      a = {2'($urandom), 1'b1};
      d = (k == 0) ? 8'hF8 : 8'($urandom);
      p = store_pulse_n;
      i_host.xfer(1'b0, 1'b0, a, d, 1'b0, q);
      chk(8'(store_pulse_n - p), 8'h01);
      chk(wIdx, a);
      chk(wDat, d);
      p = read_strobe_n;
      i_host.xfer(1'b0, 1'b1, a, 8'h00, 1'b0, q);
      chk(q, rdVal(a));
      chk(8'(read_strobe_n - p), 8'h01);
      chk(rIdx, a);
      chk(oeN, 1'b1);
    end
    p = store_pulse_n + read_strobe_n;
    i_host.xfer(1'b0, 1'b0, 3'h3, 8'h5A, 1'b1, q);
    i_host.xfer(1'b0, 1'b1, 3'h3, 8'h00, 1'b1, q);
    chk(8'(store_pulse_n + read_strobe_n - p), 8'h00);
    chk(q, 8'hFF);
    // ----------------------------------------------------------------
    // shared address/data bus
    // ----------------------------------------------------------------
    for (int k = 0; k < 4; k++) begin
      a = 3'($urandom);
      d = 8'($urandom);
      i_host.latch(a, 5'($urandom));
      i_host.xfer(1'b0, 1'b0, 3'h0, d, 1'b0, q);
      chk(wIdx, a);
      chk(wDat, d);
      i_host.xfer(1'b0, 1'b1, 3'h0, 8'h00, 1'b0, q);
      chk(q, rdVal(a));
      chk(rIdx, a);
    end
    // ----------------------------------------------------------------
    // direction plus data strobe host, then reset
    // ----------------------------------------------------------------
    for (int k = 0; k < 4; k++) begin
      a = {2'($urandom), 1'b1};
      d = 8'($urandom);
      p = store_pulse_n;
      i_host.xfer(1'b1, 1'b0, a, d, 1'b0, q);
      chk(8'(store_pulse_n - p), 8'h01);
      chk(wDat, d);
      chk(is68, 1'b1);
      i_host.xfer(1'b1, 1'b1, a, 8'h00, 1'b0, q);
      chk(q, rdVal(a));
      chk(rIdx, a);
    end
    iSt = 8'hFF;
    iMk = 8'hFF;
    @(negedge mclk);
    resetn = 1'b0;
    @(negedge mclk);
    chk(irqN, 1'b1);
    chk(oeN, 1'b1);
    chk(is68, 1'b0);
    resetn = 1'b1;
    repeat (2) @(negedge mclk);
    chk(irqN, 1'b0);
    close_out();
  end
endmodule : tb_top
